//--- rtl/misc_exec.sv
// misc_exec: executes a small group of 8-bit core instructions
// assumes: apb master feeds instructions and wake events; one pclk
// Notes on behaviour
// - return_from_interrupt pops the last stacked pc into pc
// - return from ordinary interrupt selects the normal flag pair
// - return from nmi selects normal or interrupt flags per entry level
// - return_from_interrupt clears interrupt_mask, and clears nmi mask only when returning from nmi
// - empty stack: return continues at the following instruction
// - reset enters nmi level; software returns to go normal
// - rotate_left_carry rotates accumulator through carry, sets zero, opcode ad
// - bit set forces bit of register or accumulator (ff), flags kept
// - shift_left_accum adds accumulator to itself, 5f ff
// - stop halts core, oscillator, peripherals; flags kept
// - stopped core wakes only on external interrupt or reset
// - subtract accumulator minus accumulator, pointer, indirect or direct source
// - subtract sets zero on zero, carry when accumulator below source
// - subtract_immediate subtracts a one-byte operand, two bytes long
// - wait (ed) suspends execution, oscillator runs, flags kept
// - wait ends on peripheral interrupt, external interrupt or reset
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module misc_exec (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power control
    output logic osc_enable,
    output logic periph_enable
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum {
        EX_IDLE,
        EX_BUSY
    } ex_t;
    ex_t ex_r, ex_nxt;
    misc_exec_pkg::run_t run_r, run_nxt;
    misc_exec_pkg::level_t level_r, level_nxt;
    logic nmi_from_int_r, nmi_from_int_nxt;
    logic int_mask_r, int_mask_nxt;
    logic nmi_mask_r, nmi_mask_nxt;
    logic [7:0] accum_r, accum_nxt;
    logic [11:0] pc_r, pc_nxt;
    logic [2:0] cyc_r, cyc_nxt;
    logic [7:0] regs_r [128];
    logic [7:0] ptr_r [4];
    logic reg_we;
    logic [7:0] reg_wa;
    logic [7:0] reg_wd;
    logic flag_wr;
    logic c_new;
    logic z_new;
    logic c_cur;
    logic z_cur;
    logic [11:0] top_pc;
    logic stk_empty;
    logic stk_pop;
    logic stk_push;
    logic [7:0] op;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [7:0] src;
    logic [8:0] diff;
    logic [8:0] dbl;
    logic wr_req;
    logic rd_req;
    logic instr_go;
    // ------------------------------------------------------------
    // apb slave: zero wait, errors on busy instruction writes
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign wr_req = psel && penable && pwrite;
    assign rd_req = psel && !pwrite;
    assign op = pwdata[7:0];
    assign arg1 = pwdata[15:8];
    assign arg2 = pwdata[23:16];
    assign instr_go = wr_req && paddr == misc_exec_pkg::REG_INSTR
        && ex_r == EX_IDLE && run_r == misc_exec_pkg::RUN_ACTIVE;
    assign pslverr = psel && penable && pwrite && paddr == misc_exec_pkg::REG_INSTR
        && !instr_go;
    assign stk_push = wr_req && paddr == misc_exec_pkg::REG_PUSH;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_req && !penable) begin
            case (paddr)
                misc_exec_pkg::REG_ACCUM: prdata <= {24'h00_0000, accum_r};
                misc_exec_pkg::REG_STATUS: prdata <= {22'h00_0000, run_r, level_r,
                    nmi_mask_r, int_mask_r, stk_empty, 1'b0, z_cur, c_cur};
                misc_exec_pkg::REG_PC: prdata <= {20'h0_0000, pc_r};
                default: begin
                    if (paddr[7]) begin
                        prdata <= {24'h00_0000, regs_r[paddr[6:0]]};
                    end else begin
                        prdata <= misc_exec_pkg::ERR_DATA;
                    end
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // operand fetch
    // ------------------------------------------------------------
    always_comb begin
        src = 8'h00;
        if (op == misc_exec_pkg::OP_SUB_IND_X) begin
            src = regs_r[ptr_r[0][6:0]];
        end else if (op == misc_exec_pkg::OP_SUB_IND_Y) begin
            src = regs_r[ptr_r[1][6:0]];
        end else if (op == misc_exec_pkg::OP_SUBTRACT_IMMEDIATE) begin
            src = arg1;
        end else if (arg1 == misc_exec_pkg::ADDR_ACCUM) begin
            src = accum_r;
        end else if (arg1[7:2] == misc_exec_pkg::ADDR_REG_X[7:2]) begin
            src = ptr_r[arg1[1:0]];
        end else begin
            src = regs_r[arg1[6:0]];
        end
    end
    assign diff = {1'b0, accum_r} - {1'b0, src};
    assign dbl = {1'b0, accum_r} + {1'b0, accum_r};
    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    always_comb begin
        ex_nxt = ex_r;
        run_nxt = run_r;
        level_nxt = level_r;
        nmi_from_int_nxt = nmi_from_int_r;
        int_mask_nxt = int_mask_r;
        nmi_mask_nxt = nmi_mask_r;
        accum_nxt = accum_r;
        pc_nxt = pc_r;
        cyc_nxt = cyc_r;
        reg_we = 1'b0;
        reg_wa = arg1;
        reg_wd = 8'h00;
        flag_wr = 1'b0;
        c_new = c_cur;
        z_new = z_cur;
        stk_pop = 1'b0;
        if (ex_r == EX_BUSY) begin
            cyc_nxt = cyc_r - 3'd1;
            if (cyc_r == 3'd1) begin
                ex_nxt = EX_IDLE;
            end
        end
        if (instr_go) begin
            ex_nxt = EX_BUSY;
            cyc_nxt = misc_exec_pkg::CYC_LONG - 3'd1;
            pc_nxt = pc_r + 12'd1;
            if (op == misc_exec_pkg::OP_RETURN_FROM_INTERRUPT) begin
                cyc_nxt = misc_exec_pkg::CYC_SHORT - 3'd1;
                int_mask_nxt = 1'b0;
                if (!stk_empty) begin
                    pc_nxt = top_pc;
                    stk_pop = 1'b1;
                end
                // empty stack keeps pc + 1
                if (level_r == misc_exec_pkg::LVL_NMI) begin
                    nmi_mask_nxt = 1'b0;
                    level_nxt = nmi_from_int_r ? misc_exec_pkg::LVL_INT
                        : misc_exec_pkg::LVL_NORMAL;
                    nmi_from_int_nxt = 1'b0;
                end else begin
                    level_nxt = misc_exec_pkg::LVL_NORMAL;
                end
            end else if (op == misc_exec_pkg::OP_RLC) begin
                accum_nxt = {accum_r[6:0], c_cur};
                flag_wr = 1'b1;
                c_new = accum_r[7];
                z_new = ({accum_r[6:0], c_cur} == 8'h00);
            end else if (op[4:0] == misc_exec_pkg::OP_SET_LOW) begin
                pc_nxt = pc_r + 12'd2;
                if (arg1 == misc_exec_pkg::ADDR_ACCUM) begin
                    accum_nxt = accum_r | (8'h01 << op[7:5]);
                end else begin
                    reg_we = 1'b1;
                    reg_wd = src | (8'h01 << op[7:5]);
                end
            end else if (op == misc_exec_pkg::OP_ADD_DIR
                && arg1 == misc_exec_pkg::ADDR_ACCUM) begin
                pc_nxt = pc_r + 12'd2;
                accum_nxt = dbl[7:0];
                flag_wr = 1'b1;
                c_new = dbl[8];
                z_new = (dbl[7:0] == 8'h00);
            end else if (op == misc_exec_pkg::OP_STOP) begin
                cyc_nxt = misc_exec_pkg::CYC_SHORT - 3'd1;
                run_nxt = misc_exec_pkg::RUN_STOP;
            end else if (op == misc_exec_pkg::OP_WAIT) begin
                cyc_nxt = misc_exec_pkg::CYC_SHORT - 3'd1;
                run_nxt = misc_exec_pkg::RUN_WAIT;
            end else if (op == misc_exec_pkg::OP_SUB_IND_X
                || op == misc_exec_pkg::OP_SUB_IND_Y
                || op == misc_exec_pkg::OP_SUB_DIR
                || op == misc_exec_pkg::OP_SUBTRACT_IMMEDIATE) begin
                if (op == misc_exec_pkg::OP_SUB_DIR || op == misc_exec_pkg::OP_SUBTRACT_IMMEDIATE) begin
                    pc_nxt = pc_r + 12'd2;
                end
                accum_nxt = diff[7:0];
                flag_wr = 1'b1;
                c_new = diff[8];
                z_new = (diff[7:0] == 8'h00);
            end
        end
        // wake events written at the wake register: bit0 ext, bit1 periph
        if (wr_req && paddr == misc_exec_pkg::REG_WAKE) begin
            case (run_r)
                misc_exec_pkg::RUN_STOP: begin
                    if (pwdata[0]) begin
                        run_nxt = misc_exec_pkg::RUN_ACTIVE;
                    end
                end
                misc_exec_pkg::RUN_WAIT: begin
                    if (pwdata[0] || pwdata[1]) begin
                        run_nxt = misc_exec_pkg::RUN_ACTIVE;
                    end
                end
                default: begin
                    run_nxt = run_r;
                end
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ex_r <= EX_IDLE;
            run_r <= misc_exec_pkg::RUN_ACTIVE;
            level_r <= misc_exec_pkg::LVL_NMI;
            nmi_from_int_r <= 1'b0;
            int_mask_r <= 1'b1;
            nmi_mask_r <= 1'b1;
            accum_r <= 8'h00;
            pc_r <= misc_exec_pkg::PC_RESET;
            cyc_r <= 3'd0;
        end else begin
            ex_r <= ex_nxt;
            run_r <= run_nxt;
            level_r <= level_nxt;
            nmi_from_int_r <= nmi_from_int_nxt;
            int_mask_r <= int_mask_nxt;
            nmi_mask_r <= nmi_mask_nxt;
            accum_r <= accum_nxt;
            pc_r <= pc_nxt;
            cyc_r <= cyc_nxt;
        end
    end
    // ------------------------------------------------------------
    // data space: direct apb writes and bit-set writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (reg_we && reg_wa[7:2] == misc_exec_pkg::ADDR_REG_X[7:2]) begin
            ptr_r[reg_wa[1:0]] <= reg_wd;
        end else if (reg_we) begin
            regs_r[reg_wa[6:0]] <= reg_wd;
        end else if (wr_req && paddr[7]) begin
            regs_r[paddr[6:0]] <= pwdata[7:0];
            if (paddr[6:2] == 5'h00) begin
                ptr_r[paddr[1:0]] <= pwdata[7:0];
            end
        end
    end
    assign osc_enable = (run_r != misc_exec_pkg::RUN_STOP);
    assign periph_enable = (run_r == misc_exec_pkg::RUN_ACTIVE)
        || (run_r == misc_exec_pkg::RUN_WAIT);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    pc_stack pc_stack_inst (
        .pclk(pclk),
        .presetn(presetn),
        .push(stk_push),
        .push_pc(pwdata[11:0]),
        .pop(stk_pop),
        .top_pc(top_pc),
        .empty(stk_empty)
    );
    flag_bank flag_bank_inst (
        .pclk(pclk),
        .presetn(presetn),
        .level(level_r),
        .wr(flag_wr),
        .c_in(c_new),
        .z_in(z_new),
        .c_out(c_cur),
        .z_out(z_cur)
    );
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_return_from_interrupt_pop;
        @(posedge pclk) disable iff (!presetn)
        instr_go && op == misc_exec_pkg::OP_RETURN_FROM_INTERRUPT && !stk_empty |=> pc_r == $past(top_pc);
    endproperty
    a_return_from_interrupt_pop: assert property (p_return_from_interrupt_pop) else $error("pop pc wrong");
    property p_return_from_interrupt_norm;
        @(posedge pclk) disable iff (!presetn)
        instr_go && op == misc_exec_pkg::OP_RETURN_FROM_INTERRUPT && level_r != misc_exec_pkg::LVL_NMI
        |=> level_r == misc_exec_pkg::LVL_NORMAL;
    endproperty
    a_return_from_interrupt_norm: assert property (p_return_from_interrupt_norm) else $error("level not normal");
    property p_return_from_interrupt_mask;
        @(posedge pclk) disable iff (!presetn)
        instr_go && op == misc_exec_pkg::OP_RETURN_FROM_INTERRUPT |=> !int_mask_r;
    endproperty
    a_return_from_interrupt_mask: assert property (p_return_from_interrupt_mask) else $error("mask kept");
    property p_return_from_interrupt_empty;
        @(posedge pclk) disable iff (!presetn)
        instr_go && op == misc_exec_pkg::OP_RETURN_FROM_INTERRUPT && stk_empty
        |=> pc_r == $past(pc_r) + 12'd1;
    endproperty
    a_return_from_interrupt_empty: assert property (p_return_from_interrupt_empty) else $error("empty pop moved");
    property p_rlc;
        @(posedge pclk) disable iff (!presetn)
        instr_go && op == misc_exec_pkg::OP_RLC |=> c_cur == $past(accum_r[7])
            && accum_r == {$past(accum_r[6:0]), $past(c_cur)};
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate wrong");
    property p_sub_c;
        @(posedge pclk) disable iff (!presetn)
        instr_go && op == misc_exec_pkg::OP_SUBTRACT_IMMEDIATE |=> c_cur == ($past(accum_r) < $past(arg1))
            && accum_r == 8'($past(accum_r) - $past(arg1));
    endproperty
    a_sub_c: assert property (p_sub_c) else $error("subtract wrong");
    property p_stop_hold;
        @(posedge pclk) disable iff (!presetn)
        run_r == misc_exec_pkg::RUN_STOP && !(wr_req && paddr == misc_exec_pkg::REG_WAKE
            && pwdata[0]) |=> run_r == misc_exec_pkg::RUN_STOP;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left early");
    property p_wait_osc;
        @(posedge pclk) disable iff (!presetn)
        instr_go && op == misc_exec_pkg::OP_WAIT |=> osc_enable && !instr_go
            && run_r == misc_exec_pkg::RUN_WAIT;
    endproperty
    a_wait_osc: assert property (p_wait_osc) else $error("wait state wrong");
endmodule
`default_nettype wire

//--- common/misc_exec_pkg.sv
// misc_exec_pkg: opcodes, cycle counts, apb offsets and reset values
// assumes: used by the instruction executor and its helper modules
package misc_exec_pkg;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_RETURN_FROM_INTERRUPT = 8'h4d;
    localparam logic [7:0] OP_RLC = 8'had;
    localparam logic [7:0] OP_STOP = 8'h6d;
    localparam logic [7:0] OP_WAIT = 8'hed;
    localparam logic [7:0] OP_SUB_IND_X = 8'hc7;
    localparam logic [7:0] OP_SUB_IND_Y = 8'hcf;
    localparam logic [7:0] OP_SUB_DIR = 8'hdf;
    localparam logic [7:0] OP_ADD_DIR = 8'h5f;
    localparam logic [7:0] OP_SUBTRACT_IMMEDIATE = 8'hd7;
    localparam logic [4:0] OP_SET_LOW = 5'h1b;
    localparam logic [7:0] ADDR_ACCUM = 8'hff;
    localparam logic [7:0] ADDR_REG_X = 8'h80;
    localparam logic [7:0] ADDR_REG_Y = 8'h81;
    localparam logic [7:0] ADDR_REG_V = 8'h82;
    localparam logic [7:0] ADDR_REG_W = 8'h83;
    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] CYC_SHORT = 3'd2;
    localparam logic [2:0] CYC_LONG = 3'd4;
    // ------------------------------------------------------------
    // stack and levels
    // ------------------------------------------------------------
    localparam int STACK_DEPTH = 6;
    localparam logic [11:0] PC_RESET = 12'h000;
    // ------------------------------------------------------------
    // apb map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_WAKE = 8'h04;
    localparam logic [7:0] REG_ACCUM = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_PUSH = 8'h14;
    localparam logic [7:0] REG_DATA_BASE = 8'h80;
    localparam logic [31:0] ERR_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        LVL_NORMAL,
        LVL_INT,
        LVL_NMI
    } level_t;
    typedef enum logic [1:0] {
        RUN_ACTIVE,
        RUN_WAIT,
        RUN_STOP
    } run_t;
endpackage

//--- rtl/pc_stack.sv
// pc_stack: last-in first-out store of return program counters
// assumes: push and pop never in the same cycle
`timescale 1ns/10ps
`default_nettype none
module pc_stack #(
    parameter int DEPTH = misc_exec_pkg::STACK_DEPTH
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // push and pop
    input wire logic push,
    input wire logic [11:0] push_pc,
    input wire logic pop,
    output logic [11:0] top_pc,
    output logic empty
);
    logic [11:0] mem_r [DEPTH];
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && cnt_r != 4'(DEPTH)) begin
            cnt_nxt = cnt_r + 4'd1;
        end else if (pop && cnt_r != 4'd0) begin
            cnt_nxt = cnt_r - 4'd1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'd0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    always_ff @(posedge pclk) begin
        if (push && cnt_r != 4'(DEPTH)) begin
            mem_r[cnt_r[2:0]] <= push_pc;
        end
    end
    assign empty = (cnt_r == 4'd0);
    assign top_pc = empty ? 12'h000 : mem_r[3'(cnt_r - 4'd1)];
endmodule
`default_nettype wire

//--- rtl/flag_bank.sv
// flag_bank: carry/zero pairs for normal, interrupt and nmi levels
// assumes: only the selected level's pair is written
`timescale 1ns/10ps
`default_nettype none
module flag_bank (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level select and update
    input wire misc_exec_pkg::level_t level,
    input wire logic wr,
    input wire logic c_in,
    input wire logic z_in,
    output logic c_out,
    output logic z_out
);
    logic [2:0] c_r;
    logic [2:0] z_r;
    logic [2:0] c_nxt;
    logic [2:0] z_nxt;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_lvl
            always_comb begin
                c_nxt[g] = (wr && level == misc_exec_pkg::level_t'(g)) ? c_in : c_r[g];
                z_nxt[g] = (wr && level == misc_exec_pkg::level_t'(g)) ? z_in : z_r[g];
            end
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_r <= 3'b000;
            z_r <= 3'b000;
        end else begin
            c_r <= c_nxt;
            z_r <= z_nxt;
        end
    end
    assign c_out = c_r[level];
    assign z_out = z_r[level];
endmodule
`default_nettype wire

//--- verif/tb_misc_exec.sv
// tb_misc_exec: self-checking bench for the instruction executor
// assumes: misc_exec_pkg compiled first; apb slave answers with pready
`timescale 1ns/10ps
`default_nettype none
module tb_misc_exec;
    // ------------------------------------------------------------
    // signals and table
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] da;
        logic [7:0] dd;
        logic [31:0] instr;
        logic [7:0] acc;
        logic [1:0] zc;
    } row_t;
    // data write (da 0 = none), instruction word, accumulator, {z,c}
    row_t rows [19] = '{
        '{8'h00, 8'h00, 32'h0000_ffdf, 8'h00, 2'h2},
        '{8'h00, 8'h00, 32'h0000_fffb, 8'h80, 2'h2},
        '{8'h00, 8'h00, 32'h0000_ff7b, 8'h88, 2'h2},
        '{8'h00, 8'h00, 32'h0000_ff1b, 8'h89, 2'h2},
        '{8'h00, 8'h00, 32'h0000_00ad, 8'h12, 2'h1},
        '{8'h00, 8'h00, 32'h0000_00ad, 8'h25, 2'h0},
        '{8'h00, 8'h00, 32'h0000_ff5f, 8'h4a, 2'h0},
        '{8'h00, 8'h00, 32'h0000_fffb, 8'hca, 2'h0},
        '{8'h00, 8'h00, 32'h0000_ff5f, 8'h94, 2'h1},
        '{8'h00, 8'h00, 32'h0000_94d7, 8'h00, 2'h2},
        '{8'h00, 8'h00, 32'h0000_01d7, 8'hff, 2'h1},
        '{8'h80, 8'hef, 32'h0000_80df, 8'h10, 2'h0},
        '{8'h81, 8'h10, 32'h0000_81df, 8'h00, 2'h2},
        '{8'h82, 8'h01, 32'h0000_82df, 8'hff, 2'h1},
        '{8'h83, 8'h0f, 32'h0000_83df, 8'hf0, 2'h0},
        '{8'h90, 8'h30, 32'h0000_90df, 8'hc0, 2'h0},
        '{8'h80, 8'h90, 32'h0000_00c7, 8'h90, 2'h0},
        '{8'h81, 8'h90, 32'h0000_00cf, 8'h60, 2'h0},
        '{8'h90, 8'h61, 32'h0000_00cf, 8'hff, 2'h1}
    };
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic osc_enable, periph_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv, p0;
    int fail_count, samples_checked;
    misc_exec misc_exec_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_enable(osc_enable),
        .periph_enable(periph_enable)
    );
    always #5 pclk = ~pclk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    // hold keeps psel up so the next setup follows at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input bit hold, output logic [31:0] r, output logic err);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        err = pslverr;
        if (!hold) begin
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge pclk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, 1'b0, rv, e);
    endtask
    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0000_0000, 1'b0, rv, e);
        chk(name, exp, rv);
    endtask
    task automatic ex(input logic [31:0] w);
        wr(misc_exec_pkg::REG_INSTR, w);
        chk("pslverr", 32'h0000_0000, {31'h0000_0000, e});
        repeat (3) @(posedge pclk);
    endtask
    task automatic st(input logic [31:0] exp);
        rdc("status", misc_exec_pkg::REG_STATUS, exp);
    endtask
    task automatic ac(input logic [31:0] exp);
        rdc("accum", misc_exec_pkg::REG_ACCUM, exp);
    endtask
    task automatic pcc(input logic [31:0] exp);
        rdc("pc", misc_exec_pkg::REG_PC, exp);
    endtask
    task automatic pins(input logic [31:0] exp);
        chk("power", exp, {30'h0000_0000, osc_enable, periph_enable});
    endtask
    task automatic after_reset;
        apb(1'h0, misc_exec_pkg::REG_STATUS, 32'h0000_0000, 1'b0, rv, e);
        chk("status", 32'h0000_00b8, rv & 32'h0000_03fc);
        ac(32'h0000_0000);
        pcc(32'h0000_0000);
        pins(32'h0000_0003);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'h0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fail_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        after_reset;
        ex(32'h0000_01d7);
        ac(32'h0000_00ff);
        st(32'h0000_00b9);
        apb(1'h0, misc_exec_pkg::REG_PC, 32'h0000_0000, 1'b0, p0, e);
        ex({24'h00_0000, misc_exec_pkg::OP_RETURN_FROM_INTERRUPT});
        pcc(p0 + 32'h0000_0001);
        st(32'h0000_0008);
        ac(32'h0000_00ff);
        wr(misc_exec_pkg::REG_PUSH, 32'h0000_0123);
        wr(misc_exec_pkg::REG_PUSH, 32'h0000_03df);
        ex({24'h00_0000, misc_exec_pkg::OP_RETURN_FROM_INTERRUPT});
        pcc(32'h0000_03df);
        st(32'h0000_0000);
        ex({24'h00_0000, misc_exec_pkg::OP_RETURN_FROM_INTERRUPT});
        pcc(32'h0000_0123);
        st(32'h0000_0008);
        wr(8'h90, 32'h0000_0000);
        ex(32'h0000_909b);
        rdc("data", 8'h90, 32'h0000_0010);
        st(32'h0000_0008);
        foreach (rows[i]) begin
            if (rows[i].da != 8'h00) wr(rows[i].da, {24'h00_0000, rows[i].dd});
            ex(rows[i].instr);
            ac({24'h00_0000, rows[i].acc});
            st({28'h000_0000, 2'h2, rows[i].zc});
        end
        // second instruction lands while the first is busy
        apb(1'h1, misc_exec_pkg::REG_INSTR, 32'h0000_ff5f, 1'b1, rv, e);
        apb(1'h1, misc_exec_pkg::REG_INSTR, 32'h0000_0fd7, 1'b0, rv, e);
        chk("pslverr", 32'h0000_0001, {31'h0000_0000, e});
        repeat (3) @(posedge pclk);
        ac(32'h0000_00fe);
        st(32'h0000_0009);
        for (int i = 1; i <= 2; i++) begin
            ex({24'h00_0000, misc_exec_pkg::OP_WAIT});
            st(32'h0000_0109);
            pins(32'h0000_0003);
            apb(1'h1, misc_exec_pkg::REG_INSTR, 32'h0000_0fd7, 1'b0, rv, e);
            chk("pslverr", 32'h0000_0001, {31'h0000_0000, e});
            wr(misc_exec_pkg::REG_WAKE, 32'(i));
            st(32'h0000_0009);
        end
        ac(32'h0000_00fe);
        // no converter sits behind this block, so nothing to turn off first
        ex({24'h00_0000, misc_exec_pkg::OP_STOP});
        st(32'h0000_0209);
        pins(32'h0000_0000);
        wr(misc_exec_pkg::REG_WAKE, 32'h0000_0002);
        st(32'h0000_0209);
        wr(misc_exec_pkg::REG_WAKE, 32'h0000_0001);
        st(32'h0000_0009);
        pins(32'h0000_0003);
        ac(32'h0000_00fe);
        rdc("unmapped", 8'h18, 32'h0000_0000);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        after_reset;
        summarize;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        summarize;
    end
endmodule
`default_nettype wire
